// File: dv/lsd_ctrl_model.sv
// controller model that shifts column bits and strobes the latch
`default_nettype none
module lsd_ctrl_model (
  // clock
  input  wire logic clock,
  // stage 20 of the driver, for chaining
  input  wire logic first_half_serial_out,
  // serial pins toward the driver
  output logic      shift_clock,
  output logic      first_half_serial_in,
  output logic      second_half_serial_in,
  output logic      latch_strobe,
  output logic      frame_alternation
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    shift_clock = 1'b1;
    first_half_serial_in = 1'b0;
    second_half_serial_in = 1'b1;
    latch_strobe = 1'b0;
    frame_alternation = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  // column 1 and column 21 go first; lines scrambled after hold
  task automatic send_frame(input logic [39:0] cols, input logic df);
    frame_alternation = df;
    for (int i = 0; i < 20; i++)
    begin
      first_half_serial_in = cols[i];
      second_half_serial_in = cols[20+i];
      wait_n(8);
      shift_clock = 1'b0;
      wait_n(8);
      shift_clock = 1'b1;
      first_half_serial_in = ~cols[i];
      second_half_serial_in = ~cols[20+i];
      wait_n(2);
    end
  endtask

  // one 40-stage chain: columns 21 to 40 go in first, second input follows stage 20
  task automatic send_chained(input logic [39:0] cols, input logic df);
    frame_alternation = df;
    for (int k = 0; k < 40; k++)
    begin
      first_half_serial_in = cols[(k + 20) % 40];
      second_half_serial_in = first_half_serial_out;
      wait_n(8);
      shift_clock = 1'b0;
      wait_n(8);
      shift_clock = 1'b1;
      wait_n(2);
    end
  endtask

  task automatic load_latch();
    wait_n(26);
    latch_strobe = 1'b1;
    wait_n(14);
    latch_strobe = 1'b0;
    wait_n(2);
  endtask
endmodule // lsd_ctrl_model
`default_nettype wire

// File: dv/test_lsd_driver.sv
// self-checking bench for the segment shift latch driver
`include "lsd_defs.svh"
`default_nettype none
module test_lsd_driver;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, rst_n, segment_ready, shift_clock, latch_strobe, frame_alternation;
  logic        first_half_serial_in, second_half_serial_in, first_half_serial_out, cascade_serial_out;
  logic        segment_valid, contents_known;
  logic [79:0] segment_outputs, last_word;
  logic [7:0]  lfsr;
  logic        q1[$], q2[$];
  int          n_fail, tests_run;

  lsd_ctrl_model u_lsd_ctrl_model (.clock(clock), .shift_clock(shift_clock),
    .first_half_serial_out(first_half_serial_out),
    .first_half_serial_in(first_half_serial_in), .second_half_serial_in(second_half_serial_in),
    .latch_strobe(latch_strobe), .frame_alternation(frame_alternation));

  lsd_driver #(.HALF(`LSD_HALF_LEN)) u_lsd_driver (.clock(clock), .rst_n(rst_n),
    .shift_clock(shift_clock), .first_half_serial_in(first_half_serial_in),
    .second_half_serial_in(second_half_serial_in), .latch_strobe(latch_strobe),
    .frame_alternation(frame_alternation), .first_half_serial_out(first_half_serial_out),
    .cascade_serial_out(cascade_serial_out), .segment_outputs(segment_outputs),
    .segment_valid(segment_valid), .segment_ready(segment_ready), .contents_known(contents_known));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [79:0] expect_levels(input logic [39:0] cols, input logic df);
    expect_levels = '0;
    for (int n = 0; n < 40; n++)
      if (cols[n])
        expect_levels[2*n +: 2] = df ? `LSD_LVL_BOTTOM : `LSD_LVL_TOP;
      else
        expect_levels[2*n +: 2] = df ? `LSD_LVL_LOWER : `LSD_LVL_UPPER;
  endfunction

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // receiver stalls at random; keeps the last word seen with valid high, taken or not
  task automatic drain(input int cycles);
    repeat (cycles)
    begin
      lfsr = lfsr_next(lfsr);
      segment_ready = lfsr[0] | lfsr[1];
      if (segment_valid === 1'b1)
        last_word = segment_outputs;
      @(negedge clock);
    end
    segment_ready = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  always @(negedge shift_clock)
    if (rst_n === 1'b1)
    begin
      q1.push_back(first_half_serial_in);
      q2.push_back(second_half_serial_in);
    end

  always @(posedge shift_clock)
    if (q1.size() >= 20)
    begin
      check("first_half_serial_out", {79'h0, first_half_serial_out}, {79'h0, q1[q1.size()-20]});
      check("cascade_serial_out", {79'h0, cascade_serial_out}, {79'h0, q2[q2.size()-20]});
    end

  initial
  begin
    logic [39:0] cols, prev;
    logic        df;
    n_fail = 0;
    tests_run = 0;
    lfsr = 8'h59;
    segment_ready = 1'b0;
    last_word = '0;
    prev = '0;
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    for (int f = 0; f < 7; f++)
    begin
      lfsr = lfsr_next(lfsr);
      df = (f < 2) ? ~f[0] : lfsr[2];
      for (int i = 0; i < 40; i++)
      begin
        lfsr = lfsr_next(lfsr);
        cols[i] = (f == 0) ? 1'b1 : (f == 1) ? 1'b0 : lfsr[0];
      end
      if (f == 6)
        u_lsd_ctrl_model.send_chained(cols, df);
      else
        u_lsd_ctrl_model.send_frame(cols, df);
      if (f > 0)
      begin
        drain(30);
        check("held_levels", last_word, expect_levels(prev, df));
      end
      else
        check("known_before_load", {79'h0, contents_known}, 80'h0);
      u_lsd_ctrl_model.load_latch();
      drain(30);
      check("latched_levels", last_word, expect_levels(cols, df));
      check("contents_known", {79'h0, contents_known}, 80'h1);
      prev = cols;
    end
    complete_run();
  end

  initial
  begin
    repeat (12000) @(posedge clock);
    n_fail++;
    complete_run();
  end
endmodule // test_lsd_driver
`default_nettype wire

// File: logic/lsd_defs.svh
// timing counts and field constants for the segment shift latch driver
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
`define LSD_HALF_LEN     20
`define LSD_SEG_COUNT    40
`define LSD_CLK_NS       10
`define LSD_LOAD_MIN_NS  125
`define LSD_LOAD_CYCLES  ((`LSD_LOAD_MIN_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS)
`define LSD_LVL_TOP      2'h0
`define LSD_LVL_UPPER    2'h1
`define LSD_LVL_LOWER    2'h2
`define LSD_LVL_BOTTOM   2'h3
`endif

// File: logic/lsd_driver.sv
// forty-column segment shift, latch and level-select logic
// Contract
// - first serial input fills columns 1 to 20
// - second serial input fills columns 21 to 40
// - both registers shift on shift clock fall
// - first serial out is stage 20
// - cascade out is stage 40
// - strobe high, latch follows shift register
// - strobe low, latch holds last values
// - segment output n from latched bit n
// - level from latched bit and alternation
`include "lsd_defs.svh"
`default_nettype none
module lsd_driver #(
  parameter int HALF = `LSD_HALF_LEN
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // serial pins from the controller
  input  wire logic                 shift_clock,
  input  wire logic                 first_half_serial_in,
  input  wire logic                 second_half_serial_in,
  input  wire logic                 latch_strobe,
  input  wire logic                 frame_alternation,
  // serial outputs
  output logic                      first_half_serial_out,
  output logic                      cascade_serial_out,
  // segment level codes, two bits per output
  output logic [2*2*HALF-1:0]       segment_outputs,
  output logic                      segment_valid,
  input  wire logic                 segment_ready,
  output logic                      contents_known
);
  localparam int SEGS = 2 * HALF;

  //////////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers
  logic [2:0] s_ck;
  logic [2:0] s_d1;
  logic [2:0] s_d2;
  logic [2:0] s_ld;
  logic [2:0] s_df;

  always_ff @(posedge clock)
  begin
    s_ck <= {s_ck[1:0], shift_clock};
    s_d1 <= {s_d1[1:0], first_half_serial_in};
    s_d2 <= {s_d2[1:0], second_half_serial_in};
    s_ld <= {s_ld[1:0], latch_strobe};
    s_df <= {s_df[1:0], frame_alternation};
  end

  // filtered levels change only when stages two and three agree
  logic ck_f;
  logic d1_f;
  logic d2_f;
  logic ld_f;
  logic df_f;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ck_f <= 1'b0;
      d1_f <= 1'b0;
      d2_f <= 1'b0;
      ld_f <= 1'b0;
      df_f <= 1'b0;
    end
    else
    begin
      if (s_ck[1] == s_ck[2]) ck_f <= s_ck[2];
      if (s_d1[1] == s_d1[2]) d1_f <= s_d1[2];
      if (s_d2[1] == s_d2[2]) d2_f <= s_d2[2];
      if (s_ld[1] == s_ld[2]) ld_f <= s_ld[2];
      if (s_df[1] == s_df[2]) df_f <= s_df[2];
    end
  end

  // falling edge of the filtered shift clock
  wire ck_new  = (s_ck[1] == s_ck[2]) ? s_ck[2] : ck_f;
  wire fall    = ck_f && !ck_new;

  //////////////////////////////////////////////////////////////////////////////
  // two 20-stage shift registers; index 0 is the entry stage
  logic [HALF-1:0] reg_a;
  logic [HALF-1:0] reg_b;

  always_ff @(posedge clock)
  begin
    if (fall)
    begin
      reg_a <= {reg_a[HALF-2:0], d1_f};
      reg_b <= {reg_b[HALF-2:0], d2_f};
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      first_half_serial_out <= 1'b0;
      cascade_serial_out    <= 1'b0;
    end
    else
    begin
      first_half_serial_out <= reg_a[HALF-1];
      cascade_serial_out    <= reg_b[HALF-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latch: column 1 is the oldest bit in the first register
  logic [SEGS-1:0] latched;
  wire  [SEGS-1:0] columns;

  genvar gi;
  generate
    for (gi = 0; gi < HALF; gi++)
    begin : g_col
      assign columns[gi]        = reg_a[HALF-1-gi];
      assign columns[HALF + gi] = reg_b[HALF-1-gi];
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (ld_f)
      latched <= columns;
  end

  // unknown until a full load has been shifted and latched
  logic [6:0] shift_count;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      shift_count    <= 7'h00;
      contents_known <= 1'b0;
    end
    else
    begin
      if (fall && shift_count < 7'(HALF))
        shift_count <= shift_count + 7'h01;
      if (ld_f && shift_count == 7'(HALF))
        contents_known <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // level selection per segment
  function automatic lsd_pkg::lsd_level_t pick_level(input logic sel, input logic alt);
    if (sel)
      pick_level = alt ? `LSD_LVL_BOTTOM : `LSD_LVL_TOP;
    else
      pick_level = alt ? `LSD_LVL_LOWER : `LSD_LVL_UPPER;
  endfunction

  wire [2*SEGS-1:0] levels;
  generate
    for (gi = 0; gi < SEGS; gi++)
    begin : g_lvl
      assign levels[2*gi +: 2] = pick_level(latched[gi], df_f);
    end
  endgenerate

  // buffered so a stalled receiver gets the latest levels; of changes made while the buffer is full, only the last is sent
  wire              buf_out_valid;
  wire [2*SEGS-1:0] buf_out_data;
  wire              buf_in_ready;
  logic [2*SEGS-1:0] sent;
  wire              change = (levels != sent) && buf_in_ready && contents_known;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sent <= '0;
    else if (change)
      sent <= levels;
  end

  lsd_skid #(.WIDTH(2*SEGS)) u_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (change),
    .in_ready  (buf_in_ready),
    .in_data   (levels),
    .out_valid (buf_out_valid),
    .out_ready (segment_ready || !segment_valid),
    .out_data  (buf_out_data)
  );

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      segment_outputs <= '0;
      segment_valid   <= 1'b0;
    end
    else if (segment_ready || !segment_valid)
    begin
      segment_valid <= buf_out_valid;
      if (buf_out_valid)
        segment_outputs <= buf_out_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // stage 19 known only after a full load; output lags the shift by one edge
  shift_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    fall && shift_count == 7'(HALF) |=> ##1 first_half_serial_out == $past(reg_a[HALF-2], 2))
    else $error("first serial out not stage 20");
  cascade_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    fall && shift_count == 7'(HALF) |=> ##1 cascade_serial_out == $past(reg_b[HALF-2], 2))
    else $error("cascade out not stage 40");
  entry_a: assert property (@(posedge clock) disable iff (!rst_n)
    fall |=> reg_a[0] == $past(d1_f) && reg_b[0] == $past(d2_f))
    else $error("entry stage missed input");
  follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    ld_f |=> latched == $past(columns))
    else $error("latch not transparent");
  hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ld_f |=> $stable(latched))
    else $error("latch changed while held");
  level_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    latched[0] && df_f |-> levels[1:0] == `LSD_LVL_BOTTOM)
    else $error("selected high alternation not bottom");
  level_non_a: assert property (@(posedge clock) disable iff (!rst_n)
    !latched[SEGS-1] && !df_f |-> levels[2*SEGS-1 -: 2] == `LSD_LVL_UPPER)
    else $error("non-selected low alternation not upper");
  known_a: assert property (@(posedge clock) disable iff (!rst_n)
    contents_known |-> shift_count == 7'(HALF))
    else $error("known before full shift");
  out_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    segment_valid && !segment_ready |=> $stable(segment_outputs) && segment_valid)
    else $error("output dropped under stall");

  shift_c: cover property (@(posedge clock) disable iff (!rst_n) fall);
  load_c:  cover property (@(posedge clock) disable iff (!rst_n) $rose(contents_known));
  stall_c: cover property (@(posedge clock) disable iff (!rst_n) segment_valid && !segment_ready);
endmodule // lsd_driver
`default_nettype wire

// File: logic/lsd_pkg.sv
// types for the segment shift latch driver
`default_nettype none
package lsd_pkg;
  typedef logic [1:0] lsd_level_t;
endpackage
`default_nettype wire

// File: logic/lsd_skid.sv
// two-entry buffer with valid and ready on both sides
`default_nettype none
module lsd_skid #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  count_range_a: assert property (@(posedge clock) disable iff (!rst_n) count <= 2'h2)
    else $error("buffer count above two");
endmodule // lsd_skid
`default_nettype wire
